// File: logic/oli_pkg.sv
// package: constants, states and carrier structs for the oob link init sequencer
package oli_pkg;
  // 20 MHz system clock
  localparam int CLK_NS = 50;
  // gen1 oob unit interval is 2/3 ns, far finer than the 50 ns clock
  // oob timing is coarse at 20 MHz; counts are kept in ns then derived
  localparam int BURST_NS = 107;          // 160 gen1 ui
  localparam int RST_GAP_NS = 320;        // 480 gen1 ui
  localparam int WAKE_GAP_NS = 107;       // 160 gen1 ui
  localparam int BURST_CYC = (BURST_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_GAP_CYC = (RST_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_GAP_CYC = (WAKE_GAP_NS + CLK_NS - 1) / CLK_NS;
  // detector off thresholds (changeable)
  localparam int RST_OFF_MIN_NS = 175;
  localparam int RST_OFF_MAX_NS = 525;
  localparam int WAKE_OFF_MIN_NS = 35;
  localparam int WAKE_OFF_MAX_NS = 175;
  // minimums round up: truncating would let a wake-spaced gap pass the reset window
  localparam int RST_OFF_MIN_CYC = (RST_OFF_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_OFF_MAX_CYC = (RST_OFF_MAX_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_OFF_MIN_CYC = (WAKE_OFF_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_OFF_MAX_CYC = (WAKE_OFF_MAX_NS + CLK_NS - 1) / CLK_NS;
  // trailing idle after comwake: at least wake max, at most 228.3 ns
  localparam int WAKE_TAIL_MAX_PS = 228300;
  localparam int WAKE_TAIL_CYC = WAKE_TAIL_MAX_PS / (CLK_NS * 1000);
  // align timeout: 54.6 us = 2048 gen1 dword times
  localparam int ALIGN_TO_NS = 54600;
  localparam int ALIGN_TO_CYC = ALIGN_TO_NS / CLK_NS;
  localparam int DET_BURSTS = 4;
  localparam int TX_BURSTS = 6;
  localparam int NONALIGN_RUN = 3;
  localparam int CNT_W = 12;
  localparam logic [1:0] SPD_FAST = 2'h2;
  localparam logic [1:0] SPD_LOW = 2'h0;

  typedef enum logic [3:0] {
    OLI_RESET = 4'h0, OLI_COMINIT = 4'h1, OLI_AWAIT_WAKE = 4'h3,
    OLI_AWAIT_NOWAKE = 4'h2, OLI_COMWAKE = 4'h6, OLI_SEND_ALIGN = 4'h7,
    OLI_READY = 4'h5, OLI_REDUCE = 4'hF, OLI_ERROR = 4'hE,
    OLI_PARTIAL = 4'h4, OLI_SLUMBER = 4'hC
  } oli_state_e;

  typedef enum logic [1:0] {
    OLI_TX_IDLE = 2'h0, OLI_TX_BURST = 2'h1, OLI_TX_D102 = 2'h2, OLI_TX_LINK = 2'h3
  } oli_tx_e;

  // received line observations from the analog front end
  typedef struct packed {
    logic squelch_n;   // burst energy present
    logic align_seen;  // aligned primitive decoded this cycle
    logic prim_valid;  // a primitive decoded this cycle
    logic locked;      // cdr locked
  } oli_rx_s;

  // link layer power controls and own cominit request
  typedef struct packed {
    logic partial;
    logic slumber;
    logic cominit_req;
  } oli_lnk_s;
endpackage

// File: logic/oli_oob_det.sv
// oob burst pattern detector with gap window checks
`timescale 1ns/1ps
module oli_oob_det
  import oli_pkg::*;
#(
  parameter int GAP_MIN = 1,
  parameter int GAP_MAX = 2
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic squelch_n,
  output logic det,
  output logic released
);
  logic sq_q;
  logic [CNT_W-1:0] gap_q;
  logic [2:0] nb_q;
  logic det_q;

  // gap timer runs while the line is idle
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      gap_q <= '0;
      sq_q <= 1'b0;
    end else begin
      sq_q <= squelch_n;
      if (squelch_n) begin
        gap_q <= '0;
      end else if (gap_q != {CNT_W{1'b1}}) begin
        gap_q <= gap_q + 1'b1;
      end
    end
  end

  // count bursts whose preceding gap sits in the window; a bad gap restarts the count at one
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      nb_q <= '0;
      det_q <= 1'b0;
    end else if (squelch_n && !sq_q) begin
      if (nb_q == 3'h0 || (gap_q >= CNT_W'(GAP_MIN) && gap_q <= CNT_W'(GAP_MAX))) begin
        if (nb_q < 3'(DET_BURSTS)) nb_q <= nb_q + 1'b1;
        if (nb_q + 1'b1 >= 3'(DET_BURSTS)) det_q <= 1'b1;
      end else begin
        nb_q <= 3'h1;
        det_q <= 1'b0;
      end
    end else if (!squelch_n && gap_q > CNT_W'(GAP_MAX)) begin
      nb_q <= '0;
      det_q <= 1'b0;
    end
  end

  assign det = det_q;
  // one-cycle pulse when the pattern ends (idle exceeds max threshold)
  assign released = det_q && !squelch_n && gap_q > CNT_W'(GAP_MAX);
endmodule

// File: logic/oli_seq.sv
// device side oob signalling and link initialization sequencer
`timescale 1ns/1ps
module oli_seq
  import oli_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire oli_rx_s rx,
  input wire oli_lnk_s lnk,
  output oli_tx_e tx_mode,
  output logic tx_send_sync,
  output logic [1:0] tx_speed,
  output logic tx_elec_idle,
  output logic hard_reset,
  output logic phy_ready,
  output logic link_up,
  output logic in_partial,
  output logic in_slumber,
  output logic init_error
);
  oli_state_e st_q;
  oli_tx_e tx_q;
  logic [CNT_W-1:0] t_q;
  logic [3:0] nb_q;
  logic [15:0] al_q;
  logic [1:0] spd_q;
  logic resume_q;
  logic [1:0] run_q;
  logic up_q;
  logic rst_det, rst_rel, wake_det, wake_rel;
  logic seq_done;

  // reset and wake pattern detectors, thresholds as constants
  oli_oob_det #(.GAP_MIN(RST_OFF_MIN_CYC), .GAP_MAX(RST_OFF_MAX_CYC)) u_rst_det (
    .clock(clock),
    .rst_b(rst_b),
    .squelch_n(rx.squelch_n),
    .det(rst_det),
    .released(rst_rel)
  );
  oli_oob_det #(.GAP_MIN(WAKE_OFF_MIN_CYC), .GAP_MAX(WAKE_OFF_MAX_CYC)) u_wake_det (
    .clock(clock),
    .rst_b(rst_b),
    .squelch_n(rx.squelch_n),
    .det(wake_det),
    .released(wake_rel)
  );

  // burst generator: six bursts then trailing idle, chooses gap per pattern
  function automatic logic [CNT_W-1:0] gap_len(input oli_state_e s);
    gap_len = (s == OLI_COMINIT) ? CNT_W'(RST_GAP_CYC) : CNT_W'(WAKE_GAP_CYC);
  endfunction

  // tail ends on its last idle cycle; one more cycle would overrun the idle limit
  assign seq_done = (nb_q == 4'(TX_BURSTS)) && (tx_q == OLI_TX_IDLE)
    && (t_q + 1'b1 >= CNT_W'(WAKE_TAIL_CYC));

  // main state machine
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= OLI_RESET;
    end else if (rst_rel) begin
      // the detector is still high in the release cycle, so release wins over the hold
      st_q <= OLI_COMINIT;
    end else if (rst_det) begin
      st_q <= OLI_RESET;
    end else if (lnk.cominit_req && st_q != OLI_COMINIT && st_q != OLI_COMWAKE) begin
      // own request from any state; a burst train in flight is finished first
      st_q <= OLI_COMINIT;
    end else begin
      unique case (st_q)
        OLI_RESET: begin
          st_q <= OLI_RESET; // left only through the release or a request above
        end
        OLI_COMINIT: begin
          if (seq_done) st_q <= OLI_AWAIT_WAKE;
        end
        OLI_AWAIT_WAKE: begin
          if (wake_det) st_q <= OLI_AWAIT_NOWAKE;
        end
        OLI_AWAIT_NOWAKE: begin
          if (!wake_det) st_q <= OLI_COMWAKE; // calibration bypassed
        end
        OLI_COMWAKE: begin
          if (seq_done) st_q <= OLI_SEND_ALIGN;
        end
        OLI_SEND_ALIGN: begin
          if (rx.align_seen && rx.locked) st_q <= OLI_READY;
          else if (al_q >= 16'(ALIGN_TO_CYC)) begin
            if (resume_q || spd_q == SPD_LOW) st_q <= OLI_ERROR;
            else st_q <= OLI_REDUCE;
          end
        end
        OLI_REDUCE: st_q <= OLI_SEND_ALIGN;
        OLI_ERROR: begin
          if (resume_q) st_q <= OLI_COMWAKE; // failed resume retries wake
        end
        OLI_READY: begin
          if (lnk.partial) st_q <= OLI_PARTIAL;
          else if (lnk.slumber) st_q <= OLI_SLUMBER;
        end
        OLI_PARTIAL: begin
          if (!lnk.partial) st_q <= wake_det ? OLI_AWAIT_NOWAKE : OLI_COMWAKE;
        end
        OLI_SLUMBER: begin
          if (!lnk.slumber) st_q <= wake_det ? OLI_AWAIT_NOWAKE : OLI_COMWAKE;
        end
        default: st_q <= OLI_RESET;
      endcase
    end
  end

  // resume flag: set on entering a power state, cleared when ready again
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      resume_q <= 1'b0;
    end else if (rst_det || st_q == OLI_READY && !lnk.partial && !lnk.slumber) begin
      resume_q <= 1'b0;
    end else if (st_q == OLI_PARTIAL || st_q == OLI_SLUMBER) begin
      resume_q <= 1'b1;
    end
  end

  // speed: highest first after fresh init, step down on timeout only
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      spd_q <= SPD_FAST;
    end else if (st_q == OLI_RESET || st_q == OLI_COMINIT) begin
      // every fresh init, answered or own, starts again at the top speed
      spd_q <= SPD_FAST;
    end else if (st_q == OLI_REDUCE) begin
      spd_q <= spd_q - 2'h1;
    end
  end

  // align timeout counter, restarted per speed attempt
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      al_q <= '0;
    end else if (st_q != OLI_SEND_ALIGN) begin
      al_q <= '0;
    end else if (al_q != 16'hFFFF) begin
      al_q <= al_q + 16'h1;
    end
  end

  // burst/gap timer: bursts and gaps are whole cycles of the oob clock
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tx_q <= OLI_TX_IDLE;
      t_q <= '0;
      nb_q <= '0;
    end else if (st_q != OLI_COMINIT && st_q != OLI_COMWAKE) begin
      tx_q <= OLI_TX_IDLE;
      t_q <= '0;
      nb_q <= '0;
    end else if (seq_done) begin
      t_q <= '0;
      nb_q <= '0;
    end else if (tx_q == OLI_TX_BURST) begin
      if (t_q + 1'b1 >= CNT_W'(BURST_CYC)) begin
        tx_q <= OLI_TX_IDLE;
        t_q <= '0;
        nb_q <= nb_q + 4'h1;
      end else begin
        t_q <= t_q + 1'b1;
      end
    end else if (nb_q < 4'(TX_BURSTS) && t_q + 1'b1 >= gap_len(st_q)) begin
      tx_q <= OLI_TX_BURST;
      t_q <= '0;
    end else begin
      t_q <= t_q + 1'b1;
    end
  end

  // non-align run detector for link establishment
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      run_q <= '0;
      up_q <= 1'b0;
    end else if (st_q != OLI_READY || rst_det) begin
      // a detected reset drops the link in the same edge as the state
      run_q <= '0;
      up_q <= 1'b0;
    end else if (rx.prim_valid) begin
      if (rx.align_seen) run_q <= '0;
      else if (run_q != 2'(NONALIGN_RUN)) run_q <= run_q + 2'h1;
      if (!rx.align_seen && run_q + 2'h1 == 2'(NONALIGN_RUN)) up_q <= 1'b1;
    end
  end

  // transmitter selection; power states use electrical idle, never static
  always_comb begin
    unique case (st_q)
      OLI_COMINIT, OLI_COMWAKE: tx_mode = tx_q;
      OLI_SEND_ALIGN, OLI_REDUCE: tx_mode = rx.locked ? OLI_TX_LINK : OLI_TX_D102;
      OLI_READY: tx_mode = OLI_TX_LINK;
      default: tx_mode = OLI_TX_IDLE;
    endcase
  end

  assign tx_elec_idle = (tx_mode == OLI_TX_IDLE); // zero differential
  assign tx_send_sync = (st_q == OLI_READY) && !up_q;
  assign tx_speed = spd_q;
  assign hard_reset = rst_det;
  assign phy_ready = (st_q == OLI_READY) && rx.locked && !tx_elec_idle;
  assign link_up = up_q;
  assign in_partial = (st_q == OLI_PARTIAL);
  assign in_slumber = (st_q == OLI_SLUMBER);
  assign init_error = (st_q == OLI_ERROR);
endmodule

// File: verif/oli_checker.sv
// port assertions for the link init sequencer
`timescale 1ns/1ps
module oli_checker
  import oli_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire oli_rx_s rx,
  input wire oli_lnk_s lnk,
  input wire oli_tx_e tx_mode,
  input wire logic tx_send_sync,
  input wire logic [1:0] tx_speed,
  input wire logic tx_elec_idle,
  input wire logic hard_reset,
  input wire logic phy_ready,
  input wire logic link_up,
  input wire logic in_partial,
  input wire logic in_slumber,
  input wire logic init_error
);
  logic [1:0] run_q;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  // run of non-align primitives, saturates at three
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) run_q <= 2'h0;
    else if (rx.align_seen) run_q <= 2'h0;
    else if (rx.prim_valid && run_q != 2'h3) run_q <= run_q + 2'h1;
  end
  AST_IDLE_LEVEL: assert property (tx_elec_idle == (tx_mode == OLI_TX_IDLE))
    else $error("idle level wrong");
  AST_PWR_QUIET: assert property ((in_partial || in_slumber) |-> tx_elec_idle && !phy_ready)
    else $error("power state not quiet");
  AST_READY_COND: assert property (phy_ready |-> rx.locked && tx_mode != OLI_TX_IDLE)
    else $error("ready without lock");
  AST_SPEED_STEP: assert property ($changed(tx_speed) |->
    tx_speed == SPD_FAST || tx_speed == $past(tx_speed) - 2'h1)
    else $error("speed jump");
  AST_ERR_HOLD: assert property ($rose(init_error) |-> $stable(tx_speed))
    else $error("speed moved at error");
  AST_SYNC_UNTIL_UP: assert property (tx_send_sync |-> !link_up && !in_partial)
    else $error("sync out of place");
  AST_LINK_RUN: assert property ($rose(link_up) |-> run_q == 2'h3)
    else $error("link up too early");
  AST_RESET_CLEARS: assert property (hard_reset |=> !phy_ready && !link_up)
    else $error("reset ignored");
  AST_COMINIT_REPLY: assert property ($fell(hard_reset) |-> ##[0:15] tx_mode == OLI_TX_BURST)
    else $error("no reply burst");
  AST_BURST_LEN: assert property ($rose(tx_mode == OLI_TX_BURST) |->
    (tx_mode == OLI_TX_BURST) [*3] ##1 tx_mode != OLI_TX_BURST)
    else $error("burst length");
endmodule
bind oli_seq oli_checker u_chk (.clock(clock), .rst_b(rst_b), .rx(rx), .lnk(lnk),
  .tx_mode(tx_mode), .tx_send_sync(tx_send_sync), .tx_speed(tx_speed),
  .tx_elec_idle(tx_elec_idle), .hard_reset(hard_reset), .phy_ready(phy_ready),
  .link_up(link_up), .in_partial(in_partial), .in_slumber(in_slumber),
  .init_error(init_error));

// File: verif/oli_host_model.sv
// host side model: oob trains, align answer, primitives
`timescale 1ns/1ps
module oli_host_model
  import oli_pkg::*;
(
  input wire logic clock,
  input wire oli_tx_e tx_mode,
  output oli_rx_s rx,
  output logic [7:0] dev_bursts
);
  oli_tx_e last_q = OLI_TX_IDLE;
  logic [7:0] cnt_q = 8'h00;
  initial rx = '0;
  // free-running count of device bursts on their first cycle; the bench takes differences
  always @(posedge clock) begin
    last_q <= tx_mode;
    if (tx_mode == OLI_TX_BURST && last_q != OLI_TX_BURST) cnt_q <= cnt_q + 8'h01;
  end
  assign dev_bursts = cnt_q;
  // six bursts, then idle long enough for the far detector to see the end
  task automatic oob(input int gap); // device output is not looked at here
    repeat (TX_BURSTS) begin
      @(posedge clock) #1 rx.squelch_n = 1'b1;
      repeat (BURST_CYC - 1) @(posedge clock);
      @(posedge clock) #1 rx.squelch_n = 1'b0;
      repeat (gap - 1) @(posedge clock);
    end
    repeat (RST_OFF_MAX_CYC + 1) @(posedge clock);
  endtask
  // lock and one align back in the same cycle, whatever the device speed
  task automatic answer();
    @(posedge clock) #1 rx.locked = 1'b1;
    rx.align_seen = 1'b1;
    rx.prim_valid = 1'b1;
    @(posedge clock) #1 rx.align_seen = 1'b0;
    rx.prim_valid = 1'b0;
  endtask
  task automatic prims(input int sp);
    repeat (NONALIGN_RUN) begin
      @(posedge clock) #1 rx.prim_valid = 1'b1;
      @(posedge clock) #1 rx.prim_valid = 1'b0;
      repeat (sp) @(posedge clock);
    end
  endtask
  task automatic quiet();
    @(posedge clock) #1 rx.locked = 1'b0;
  endtask
endmodule

// File: verif/testbench.sv
// self-checking bench for the link init sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
  $display("BAD %0t %h %h", $time, (a), (b)); end end
module testbench;
  import oli_pkg::*;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic hr_seen = 1'b0;
  oli_rx_s rx;
  oli_lnk_s lnk = '0;
  oli_tx_e tx_mode;
  logic tx_send_sync, tx_elec_idle, hard_reset, phy_ready, link_up;
  logic in_partial, in_slumber, init_error;
  logic [1:0] tx_speed;
  logic [7:0] dev_bursts;
  logic [7:0] base;
  logic [5:0] exp_q[$];
  logic [5:0] prev;
  int num_errors = 0;
  int checked = 0;
  int i;
  int bad[2] = '{RST_OFF_MIN_CYC - 1, RST_OFF_MAX_CYC + 1};
  integer seed = 32'h9711;
  always #25 clock = ~clock;
  oli_seq u_dut (.clock(clock), .rst_b(rst_b), .rx(rx), .lnk(lnk), .tx_mode(tx_mode),
    .tx_send_sync(tx_send_sync), .tx_speed(tx_speed), .tx_elec_idle(tx_elec_idle),
    .hard_reset(hard_reset), .phy_ready(phy_ready), .link_up(link_up),
    .in_partial(in_partial), .in_slumber(in_slumber), .init_error(init_error));
  oli_host_model u_host (.clock(clock), .tx_mode(tx_mode), .rx(rx), .dev_bursts(dev_bursts));
  // each status change takes the oldest note off the queue
  always @(negedge clock) begin
    if (hard_reset === 1'b1) hr_seen <= 1'b1;
    if (!rst_b) prev <= 6'h02;
    else if ({init_error, in_slumber, in_partial, phy_ready, tx_speed} !== prev) begin
      prev <= {init_error, in_slumber, in_partial, phy_ready, tx_speed};
      `CHK({init_error, in_slumber, in_partial, phy_ready, tx_speed},
        (exp_q.size() > 0) ? exp_q.pop_front() : 6'h3F)
    end
  end
  task automatic test_done();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // bounded waits; running out counts as a mismatch
  task automatic wait_q(input int lim);
    for (i = 0; exp_q.size() > 0; i++) begin
      if (i == lim) begin
        num_errors++;
        test_done();
      end
      @(negedge clock);
    end
  endtask
  task automatic wait_tx(input logic brst, input int lim);
    for (i = 0; tx_mode === OLI_TX_IDLE || (tx_mode === OLI_TX_BURST) !== brst; i++) begin
      if (i == lim) begin
        num_errors++;
        test_done();
      end
      @(negedge clock);
    end
  endtask
  task automatic init();
    hr_seen = 1'b0;
    base = dev_bursts;
    u_host.oob(RST_GAP_CYC);
    `CHK(hr_seen, 1'b1)
    wait_tx(1'b1, 30);
    repeat (80) @(negedge clock);
    `CHK(dev_bursts - base, 8'h06)
    base = dev_bursts;
    u_host.oob(WAKE_GAP_CYC);
    wait_tx(1'b0, 60);
    `CHK(dev_bursts - base, 8'h06)
    `CHK(tx_speed, SPD_FAST)
  endtask
  task automatic relink();
    wait_tx(1'b0, 60);
    exp_q = '{6'h05};
    u_host.answer();
    wait_q(10);
  endtask
  initial begin
    repeat (4) @(posedge clock);
    #1 rst_b = 1'b1;
    @(negedge clock);
    `CHK(tx_elec_idle, 1'b1)
    // gaps just outside the off window on either side
    foreach (bad[k]) begin
      hr_seen = 1'b0;
      u_host.oob(bad[k]);
      `CHK(hr_seen, 1'b0)
    end
    init();
    exp_q = '{6'h01};
    wait_q(1200);
    relink();
    `CHK(tx_send_sync, 1'b1)
    u_host.prims({$random(seed)} % 4);
    repeat (3) @(negedge clock);
    `CHK(link_up, 1'b1)
    exp_q = '{6'h09};
    @(posedge clock) #1 lnk.partial = 1'b1;
    wait_q(10);
    `CHK(tx_mode, OLI_TX_IDLE)
    u_host.quiet();
    exp_q = '{6'h01, 6'h21, 6'h01};
    @(posedge clock) #1 lnk.partial = 1'b0;
    wait_q(1300);
    relink();
    exp_q = '{6'h11};
    @(posedge clock) #1 lnk.slumber = 1'b1;
    wait_q(10);
    u_host.quiet();
    exp_q = '{6'h01};
    @(posedge clock) #1 lnk.slumber = 1'b0;
    relink();
    exp_q = '{6'h01, 6'h02};
    @(posedge clock) #1 lnk.cominit_req = 1'b1;
    wait_tx(1'b1, 20);
    @(posedge clock) #1 lnk.cominit_req = 1'b0;
    wait_q(10);
    @(posedge clock) #1 rst_b = 1'b0;
    u_host.quiet();
    rst_b = 1'b1;
    init();
    exp_q = '{6'h01, 6'h00, 6'h20};
    wait_q(3400);
    test_done();
  end
endmodule
